/* File: include/afc_regs.svh */
// Register offsets, field positions and sizes of the analog input block.
// Included by the package and the design; definitions only.
`ifndef AFC_REGS_SVH
`define AFC_REGS_SVH

`define AFC_OFF_ENTRY_LOW   8'h10
`define AFC_OFF_ENTRY_HIGH  8'h12
`define AFC_OFF_FIFO_STATUS 8'h14
`define AFC_OFF_IRQ_STATUS  8'h16
`define AFC_OFF_IRQ_MASK    8'h18
`define AFC_OFF_RESULT_POP  8'h1C

`define AFC_BIT_SCAN_END    15
`define AFC_BIT_SYNC_PULSE  12
`define AFC_BIT_NOISE_EN    9
`define AFC_BIT_UNIPOLAR    8
`define AFC_GAIN_MSB        2
`define AFC_GAIN_LSB        0
`define AFC_TYPE_MSB        14
`define AFC_TYPE_LSB        12
`define AFC_TYPE_DISCARD    3'h7
`define AFC_CHAN_MSB        5
`define AFC_CHAN_LSB        0

`define AFC_FIFO_DEPTH      512
`define AFC_CFG_DEPTH       512
`define AFC_ADC_BITS        12
`define AFC_IRQ_RESET       4'h0

`endif

/* File: include/afc_pkg.sv */
// Types shared by the analog input block.
// Assumes afc_regs.svh is on the include path.
`include "afc_regs.svh"
package afc_pkg;
  typedef struct packed {
    logic       scan_end_marker;
    logic       scan_sync_pulse_enable;
    logic       noise_injection_enable;
    logic       unipolar;
    logic [2:0] input_amplifier;
    logic [2:0] resource_type_select;
    logic [5:0] channel;
  } afc_entry_t;

  typedef struct packed {
    logic full;
    logic half_full;
    logic empty;
  } afc_flags_t;

  typedef enum logic [2:0] {
    AFC_IDLE  = 3'b001,
    AFC_ARMED = 3'b010,
    AFC_WAIT  = 3'b100
  } afc_state_t;
endpackage

/* File: src/afc_adc_fifo_scan.sv */
// Analog input control: conversion result FIFO and scan configuration memory.
// Assumes one 125 MHz clock; converter and timing controller signals are on it.
`timescale 1ns/1ps
`default_nettype none
`include "afc_regs.svh"

// What this block does
// - Reading the result register returns the oldest stored result and removes it.
// - Every finished conversion is stored unless its active entry is a discard entry or the FIFO is full.
// - Empty, half-full and full flags are produced and readable in a status register.
// - A 12-bit converter in unipolar mode gives straight binary 0x0000 to 0x0FFF.
// - A 12-bit converter in bipolar mode gives sign-extended values 0xF800 to 0x07FF.
// - A 16-bit converter gives 0x0000 to 0xFFFF unipolar and 0x8000 to 0x7FFF bipolar.
// - Low and high entry words are written into the configuration memory as one entry and stepped during scans.
// - Software marks each sequence end with bit 15; several marks in one list are allowed.
// - Entry bit 12 sends a one-cycle active-low pulse to board trigger input zero in the cycle after the strobe.
// - Entry bit 9 drives noise injection; where reserved, software writes it as one.
// - Entry bit 8 set selects unipolar straight binary, clear selects bipolar.
// - Entry bits 2 to 0 select amplifier gain 0.5, 1, 2, 5, 10, 20, 50, 100 in turn.
// - The configuration memory empties when the timing controller asserts clear.
// - Resource type 111 in high-word bits 14:12 marks a discard entry.
module afc_adc_fifo_scan
  import afc_pkg::*;
#(
  parameter int FIFO_DEPTH = `AFC_FIFO_DEPTH,
  parameter int CFG_DEPTH  = `AFC_CFG_DEPTH,
  parameter int ADC_BITS   = `AFC_ADC_BITS
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic      [15:0] reg_rdata_o,
  // Timing controller
  input  wire logic        scan_start_i,
  input  wire logic        convert_strobe_i,
  input  wire logic        cfg_clear_i,
  output logic             fifo_empty_o,
  output logic             fifo_half_full_o,
  output logic             fifo_full_o,
  output logic             board_trigger_input_zero_n_o,
  output logic             scan_end_o,
  // Converter and analog front end
  input  wire logic [15:0] adc_code_i,
  input  wire logic        adc_done_i,
  output logic             unipolar_o,
  output logic             noise_injection_enable_o,
  output logic      [2:0]  input_amplifier_o,
  output logic      [5:0]  channel_o,
  // Interrupt
  output logic             irq_o
);

  localparam int FAW = $clog2(FIFO_DEPTH);
  localparam int CAW = $clog2(CFG_DEPTH);

  // Sign-extend or pass a converter code depending on the entry's polarity
  function automatic logic [15:0] format_code(input logic [15:0] raw, input logic unip);
    logic [15:0] m;
    m = 16'hFFFF >> (16 - ADC_BITS);
    if (unip) begin
      format_code = raw & m;
    end else if (raw[ADC_BITS-1]) begin
      format_code = raw | ~m;
    end else begin
      format_code = raw & m;
    end
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Result FIFO storage
  logic [15:0]  fifo_mem [FIFO_DEPTH];
  logic [FAW-1:0] fifo_wp_q;
  logic [FAW-1:0] fifo_rp_q;
  logic [FAW:0]   fifo_cnt_q;

  // Configuration memory
  afc_entry_t   cfg_mem [CFG_DEPTH];
  logic [CAW-1:0] cfg_wp_q;
  logic [CAW:0]   cfg_cnt_q;
  logic [CAW-1:0] cfg_rp_q;
  logic [15:0]    low_word_q;

  afc_state_t   state_q;
  afc_entry_t   act_q;
  logic [3:0]   irq_stat_q;
  logic [3:0]   irq_mask_q;
  logic [3:0]   irq_stat_d;
  logic [3:0]   irq_mask_d;

  logic pop;
  logic push;
  logic cfg_full;
  logic fifo_full;
  logic wr_low;
  logic wr_high;
  logic [3:0] ev;

  assign fifo_full = (fifo_cnt_q == (FAW+1)'(FIFO_DEPTH));
  assign cfg_full  = (cfg_cnt_q == (CAW+1)'(CFG_DEPTH));
  // A read on an empty FIFO returns stale data and does not move the pointer
  assign pop     = reg_read_i && hit(reg_addr_i, `AFC_OFF_RESULT_POP) &&
                   (fifo_cnt_q != '0);
  // Discard entries complete a conversion slot but keep nothing
  assign push    = adc_done_i && (state_q == AFC_WAIT) &&
                   (act_q.resource_type_select != `AFC_TYPE_DISCARD) &&
                   !fifo_full;
  assign wr_low  = reg_write_i && hit(reg_addr_i, `AFC_OFF_ENTRY_LOW);
  assign wr_high = reg_write_i && hit(reg_addr_i, `AFC_OFF_ENTRY_HIGH);
  // Events: overflow, became full, half-full reached, scan end
  // Level events need the count to move, so a push beside a pop raises nothing
  assign ev = {adc_done_i && (state_q == AFC_WAIT) && fifo_full &&
               (act_q.resource_type_select != `AFC_TYPE_DISCARD),
               push && !pop && (fifo_cnt_q == (FAW+1)'(FIFO_DEPTH - 1)),
               push && !pop && (fifo_cnt_q == (FAW+1)'(FIFO_DEPTH / 2 - 1)),
               adc_done_i && (state_q == AFC_WAIT) && act_q.scan_end_marker};

  // Result FIFO
  always_ff @(posedge clock_i) begin
    if (push) begin
      fifo_mem[fifo_wp_q] <= format_code(adc_code_i, act_q.unipolar);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fifo_wp_q  <= '0;
      fifo_rp_q  <= '0;
      fifo_cnt_q <= '0;
    end else begin
      if (push) begin
        fifo_wp_q <= fifo_wp_q + 1'b1;
      end
      if (pop) begin
        fifo_rp_q <= fifo_rp_q + 1'b1;
      end
      fifo_cnt_q <= fifo_cnt_q + (FAW+1)'(push) - (FAW+1)'(pop);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fifo_empty_o     <= 1'b1;
      fifo_half_full_o <= 1'b0;
      fifo_full_o      <= 1'b0;
    end else begin
      fifo_empty_o     <= (fifo_cnt_q + (FAW+1)'(push) - (FAW+1)'(pop)) == '0;
      fifo_half_full_o <= (fifo_cnt_q + (FAW+1)'(push) - (FAW+1)'(pop)) >=
                          (FAW+1)'(FIFO_DEPTH / 2);
      fifo_full_o      <= (fifo_cnt_q + (FAW+1)'(push) - (FAW+1)'(pop)) ==
                          (FAW+1)'(FIFO_DEPTH);
    end
  end

  // Configuration memory: a low word is held until its high word completes the entry
  always_ff @(posedge clock_i) begin
    if (wr_high && !cfg_full && !cfg_clear_i) begin
      cfg_mem[cfg_wp_q] <= '{
        scan_end_marker:        low_word_q[`AFC_BIT_SCAN_END],
        scan_sync_pulse_enable: low_word_q[`AFC_BIT_SYNC_PULSE],
        noise_injection_enable: low_word_q[`AFC_BIT_NOISE_EN],
        unipolar:               low_word_q[`AFC_BIT_UNIPOLAR],
        input_amplifier:        low_word_q[`AFC_GAIN_MSB:`AFC_GAIN_LSB],
        resource_type_select:   reg_wdata_i[`AFC_TYPE_MSB:`AFC_TYPE_LSB],
        channel:                reg_wdata_i[`AFC_CHAN_MSB:`AFC_CHAN_LSB]
      };
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      low_word_q  <= '0;
      cfg_wp_q    <= '0;
      cfg_cnt_q   <= '0;
    end else if (cfg_clear_i) begin
      cfg_wp_q    <= '0;
      cfg_cnt_q   <= '0;
    end else begin
      if (wr_low) begin
        low_word_q  <= reg_wdata_i;
      end
      if (wr_high && !cfg_full) begin
        cfg_wp_q    <= cfg_wp_q + 1'b1;
        cfg_cnt_q   <= cfg_cnt_q + 1'b1;
      end
    end
  end

  // Scan sequencer: load entry, wait for strobe, wait for conversion done
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || cfg_clear_i) begin
      state_q  <= AFC_IDLE;
      cfg_rp_q <= '0;
      act_q    <= '0;
    end else begin
      case (state_q)
        AFC_IDLE: begin
          if (scan_start_i && cfg_cnt_q != '0) begin
            act_q   <= cfg_mem[cfg_rp_q];
            state_q <= AFC_ARMED;
          end
        end
        AFC_ARMED: begin
          if (convert_strobe_i) begin
            state_q <= AFC_WAIT;
          end
        end
        AFC_WAIT: begin
          if (adc_done_i) begin
            // Wrap past the last stored entry; several end marks split the list
            if ((CAW+1)'(cfg_rp_q) + 1'b1 >= cfg_cnt_q) begin
              cfg_rp_q <= '0;
              act_q    <= cfg_mem[0];
            end else begin
              cfg_rp_q <= cfg_rp_q + 1'b1;
              act_q    <= cfg_mem[cfg_rp_q + 1'b1];
            end
            state_q <= act_q.scan_end_marker ? AFC_IDLE : AFC_ARMED;
          end
        end
        default: begin
          state_q <= AFC_IDLE;
        end
      endcase
    end
  end

  // Front-end controls follow the active entry
  // Bit 9 passes as written; parts where it is reserved rely on software writing a one
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      unipolar_o                   <= 1'b0;
      noise_injection_enable_o     <= 1'b0;
      input_amplifier_o            <= '0;
      channel_o                    <= '0;
      board_trigger_input_zero_n_o <= 1'b1;
      scan_end_o                   <= 1'b0;
    end else begin
      unipolar_o                   <= act_q.unipolar;
      noise_injection_enable_o     <= act_q.noise_injection_enable;
      input_amplifier_o            <= act_q.input_amplifier;
      channel_o                    <= act_q.channel;
      board_trigger_input_zero_n_o <= !(convert_strobe_i && state_q == AFC_ARMED &&
                                        act_q.scan_sync_pulse_enable);
      scan_end_o                   <= ev[0];
    end
  end

  // Interrupt status: set beats a same-cycle write-one clear
  always_comb begin
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q | ev;
    if (reg_write_i && hit(reg_addr_i, `AFC_OFF_IRQ_MASK)) begin
      irq_mask_d = reg_wdata_i[3:0];
    end
    if (reg_write_i && hit(reg_addr_i, `AFC_OFF_IRQ_STATUS)) begin
      irq_stat_d = (irq_stat_q & ~reg_wdata_i[3:0]) | ev;
    end
  end

  // The level follows the next status and mask, so it drops with the clearing write
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= `AFC_IRQ_RESET;
      irq_mask_q <= `AFC_IRQ_RESET;
      irq_o      <= 1'b0;
    end else begin
      irq_mask_q <= irq_mask_d;
      irq_stat_q <= irq_stat_d;
      irq_o      <= |(irq_stat_d & irq_mask_d);
    end
  end

  // Read data one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        `AFC_OFF_RESULT_POP:  reg_rdata_o <= fifo_mem[fifo_rp_q];
        `AFC_OFF_FIFO_STATUS: reg_rdata_o <= {13'h0, fifo_full_o,
                                              fifo_half_full_o, fifo_empty_o};
        `AFC_OFF_IRQ_STATUS:  reg_rdata_o <= {12'h000, irq_stat_q};
        `AFC_OFF_IRQ_MASK:    reg_rdata_o <= {12'h000, irq_mask_q};
        default:              reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

/* File: bench/afc_adc_fifo_scan_asserts.sv */
// Port checker for the analog input control block.
// Assumes it is bound to afc_adc_fifo_scan and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module afc_adc_fifo_scan_asserts (
  // Clock, reset and register port
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_write_i,
  input wire logic        reg_read_i,
  input wire logic [15:0] reg_rdata_o,
  // Scan and flags
  input wire logic        convert_strobe_i,
  input wire logic        adc_done_i,
  input wire logic        fifo_empty_o,
  input wire logic        fifo_half_full_o,
  input wire logic        fifo_full_o,
  input wire logic        board_trigger_input_zero_n_o,
  input wire logic        scan_end_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_end_pulse;
    $past(adc_done_i) ##1 !scan_end_o;
  endsequence
  sequence s_trig_release;
    ##1 board_trigger_input_zero_n_o;
  endsequence

  property p_reset_state;
    $rose(rst_n_i) |-> fifo_empty_o && board_trigger_input_zero_n_o && !irq_o;
  endproperty
  property p_rdata_idle;
    !reg_read_i |=> reg_rdata_o == 16'h0000;
  endproperty
  property p_full_flags;
    fifo_full_o |-> fifo_half_full_o && !fifo_empty_o;
  endproperty
  // Pushes land in the cycle of the done pulse; the empty flag drops one cycle later
  property p_empty_holds;
    fifo_empty_o && !adc_done_i && !$past(adc_done_i) && !$past(adc_done_i, 2) |=> fifo_empty_o;
  endproperty
  property p_data_holds;
    !fifo_empty_o && !reg_read_i && !$past(reg_read_i) && !$past(reg_read_i, 2) |=> !fifo_empty_o;
  endproperty
  property p_trig_cause;
    !board_trigger_input_zero_n_o |-> $past(convert_strobe_i);
  endproperty
  property p_trig_width;
    $fell(board_trigger_input_zero_n_o) |-> s_trig_release;
  endproperty
  property p_scan_end;
    scan_end_o |-> s_end_pulse;
  endproperty
  property p_irq_masked;
    reg_write_i && reg_addr_i == 8'h18 && reg_wdata_i == 16'h0000 |=> ##1 !irq_o;
  endproperty

  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  a_full_flags: assert property (p_full_flags) else $error("flag set inconsistent");
  a_empty_holds: assert property (p_empty_holds) else $error("empty lost");
  a_data_holds: assert property (p_data_holds) else $error("data lost");
  a_trig_cause: assert property (p_trig_cause) else $error("trigger no strobe");
  a_trig_width: assert property (p_trig_width) else $error("trigger too long");
  a_scan_end: assert property (p_scan_end) else $error("scan end misplaced");
  a_irq_masked: assert property (p_irq_masked) else $error("masked irq high");
endmodule

bind afc_adc_fifo_scan afc_adc_fifo_scan_asserts i_chk (.clock_i, .rst_n_i, .reg_addr_i,
  .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .convert_strobe_i, .adc_done_i,
  .fifo_empty_o, .fifo_half_full_o, .fifo_full_o, .board_trigger_input_zero_n_o,
  .scan_end_o, .irq_o);
`default_nettype wire

/* File: bench/afc_host_model.sv */
// Host bus master model: one-cycle write and read strobes.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module afc_host_model (
  // Clock and read data
  input  wire logic        clock_i,
  input  wire logic [15:0] reg_rdata_i,
  // Requests
  output logic      [7:0]  reg_addr_o,
  output logic      [15:0] reg_wdata_o,
  output logic             reg_write_o,
  output logic             reg_read_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 16'h0000;
    reg_write_o = 1'b0;
    reg_read_o = 1'b0;
  end
  // A gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_write_o <= 1'b1;
    @(posedge clock_i);
    reg_write_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_read_o <= 1'b1;
    @(posedge clock_i);
    reg_read_o <= 1'b0;
    #1 d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

/* File: bench/afc_adc_fifo_scan_tb.sv */
// Self-checking bench for the analog input control block.
// Assumes the checker is bound and the host model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module afc_adc_fifo_scan_tb
  import afc_pkg::*;
;
  logic        clock_i = 1'b0;
  logic        rst_n_i;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, adc_code, rd;
  logic        reg_write, reg_read, scan_start, strobe, cfg_clear, adc_done;
  logic        empty, half, full, trig_n, scan_end, unip, noise, irq;
  logic [2:0]  gain;
  logic [5:0]  chan;
  int          mismatches = 0;
  int          comparisons = 0;

  always #4 clock_i = ~clock_i;

  // Small FIFO so that half-full is reached by a short scan
  afc_adc_fifo_scan #(.FIFO_DEPTH(4)) i_afc_adc_fifo_scan (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_write_i(reg_write),
    .reg_read_i(reg_read), .reg_rdata_o(reg_rdata), .scan_start_i(scan_start),
    .convert_strobe_i(strobe), .cfg_clear_i(cfg_clear), .fifo_empty_o(empty),
    .fifo_half_full_o(half), .fifo_full_o(full), .board_trigger_input_zero_n_o(trig_n),
    .scan_end_o(scan_end), .adc_code_i(adc_code), .adc_done_i(adc_done), .unipolar_o(unip),
    .noise_injection_enable_o(noise), .input_amplifier_o(gain), .channel_o(chan), .irq_o(irq));
  afc_host_model i_afc_host_model (.clock_i(clock_i), .reg_rdata_i(reg_rdata),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_write_o(reg_write),
    .reg_read_o(reg_read));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude;
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic start_scan;
    @(posedge clock_i);
    scan_start <= 1'b1;
    @(posedge clock_i);
    scan_start <= 1'b0;
  endtask

  // One entry: strobe, then done; cfg is {channel, gain, unipolar, noise}
  task automatic step(input logic [15:0] code, input logic [10:0] cfg, input logic trg, lst);
    @(posedge clock_i);
    strobe <= 1'b1;
    #1 chk("entry", {chan, gain, unip, noise}, cfg);
    @(posedge clock_i);
    strobe <= 1'b0;
    #1 chk("trigger", trig_n, !trg);
    @(posedge clock_i);
    adc_done <= 1'b1;
    adc_code <= code;
    @(posedge clock_i);
    adc_done <= 1'b0;
    #1 chk("scan end", scan_end, lst);
  endtask

  task automatic t_reset_state;
    chk("flags", {full, half, empty}, 16'h0001);
    i_afc_host_model.rd(8'h14, rd);
    chk("status", rd, 16'h0001);
    i_afc_host_model.rd(8'h1E, rd);
    chk("unmapped", rd, 16'h0000);
  endtask

  task automatic t_scan_formats;
    i_afc_host_model.wr(8'h18, 16'h000F);
    i_afc_host_model.rd(8'h18, rd);
    chk("mask", rd, 16'h000F);
    i_afc_host_model.wr(8'h10, 16'h1103);
    i_afc_host_model.wr(8'h12, 16'h1005);
    i_afc_host_model.wr(8'h10, 16'h0207);
    i_afc_host_model.wr(8'h12, 16'h7002);
    i_afc_host_model.wr(8'h10, 16'h8000);
    i_afc_host_model.wr(8'h12, 16'h1001);
    start_scan;
    step(16'hFFFF, {6'd5, 3'd3, 1'b1, 1'b0}, 1'b1, 1'b0);
    step(16'h0123, {6'd2, 3'd7, 1'b0, 1'b1}, 1'b0, 1'b0);
    step(16'h0800, {6'd1, 3'd0, 1'b0, 1'b0}, 1'b0, 1'b1);
    @(posedge clock_i);
    #1 chk("flags", {full, half, empty}, 16'h0002);
    chk("irq", irq, 16'h0001);
    i_afc_host_model.rd(8'h16, rd);
    chk("irq status", rd, 16'h0003);
    i_afc_host_model.rd(8'h1C, rd);
    chk("result", rd, 16'h0FFF);
    i_afc_host_model.rd(8'h1C, rd);
    chk("result", rd, 16'hF800);
    i_afc_host_model.rd(8'h14, rd);
    chk("status", rd, 16'h0001);
    i_afc_host_model.wr(8'h16, 16'h0003);
    i_afc_host_model.rd(8'h16, rd);
    chk("irq status", rd, 16'h0000);
    chk("irq", irq, 16'h0000);
  endtask

  // Clear, then eight entries covering every gain code; only the last is kept
  task automatic t_clear_gains;
    @(posedge clock_i);
    cfg_clear <= 1'b1;
    @(posedge clock_i);
    cfg_clear <= 1'b0;
    i_afc_host_model.wr(8'h18, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      i_afc_host_model.wr(8'h10, ((i == 7) ? 16'h8200 : 16'h0200) | 16'(i));
      i_afc_host_model.wr(8'h12, ((i == 7) ? 16'h1000 : 16'h7000) | 16'(i));
    end
    start_scan;
    for (int i = 0; i < 8; i++) begin
      step(16'h07FF, {6'(i), 3'(i), 1'b0, 1'b1}, 1'b0, i == 7);
    end
    i_afc_host_model.rd(8'h1C, rd);
    chk("result", rd, 16'h07FF);
    i_afc_host_model.rd(8'h16, rd);
    chk("irq status", rd, 16'h0001);
    chk("irq", irq, 16'h0000);
  endtask

  // One kept unipolar entry scanned five times: four results fill the FIFO, the fifth overflows
  task automatic t_fill_overflow;
    @(posedge clock_i);
    cfg_clear <= 1'b1;
    @(posedge clock_i);
    cfg_clear <= 1'b0;
    i_afc_host_model.wr(8'h16, 16'h000F);
    i_afc_host_model.wr(8'h18, 16'h0008);
    i_afc_host_model.wr(8'h10, 16'h8100);
    i_afc_host_model.wr(8'h12, 16'h1003);
    for (int i = 1; i <= 5; i++) begin
      start_scan;
      step(16'hF000 | 16'(i), {6'd3, 3'd0, 1'b1, 1'b0}, 1'b0, 1'b1);
    end
    @(posedge clock_i);
    #1 chk("flags", {full, half, empty}, 16'h0006);
    chk("irq", irq, 16'h0001);
    i_afc_host_model.rd(8'h16, rd);
    chk("irq status", rd, 16'h000F);
    for (int i = 1; i <= 4; i++) begin
      i_afc_host_model.rd(8'h1C, rd);
      chk("result", rd, 16'(i));
    end
    i_afc_host_model.rd(8'h14, rd);
    chk("status", rd, 16'h0001);
  endtask

  initial begin
    rst_n_i = 1'b0;
    scan_start = 1'b0;
    strobe = 1'b0;
    cfg_clear = 1'b0;
    adc_done = 1'b0;
    adc_code = 16'h0000;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset_state;
    t_scan_formats;
    t_clear_gains;
    t_fill_overflow;
    conclude;
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    conclude;
  end
endmodule
`default_nettype wire
